// [core/lcdrd_pkg.sv]
`default_nettype none

package lcdrd_pkg;

  localparam int unsigned ROWS_DEFAULT = 32;

  // Row drive codes: bit 0 selects the positive level, bit 1 the negative level.
  localparam logic [1:0] DRIVE_GROUND = 2'h0;
  localparam logic [1:0] DRIVE_POSITIVE = 2'h1;
  localparam logic [1:0] DRIVE_NEGATIVE = 2'h2;

  localparam int unsigned DRIVE_POS_BIT = 0;
  localparam int unsigned DRIVE_NEG_BIT = 1;

  localparam logic STAGE_RESET = 1'h0;
  localparam logic SHIFT_CLK_RESET = 1'h0;
  localparam logic STAGE_CLEAR = 1'h0;
  localparam logic ROW_OUT_RESET = 1'h0;
  localparam logic SERIAL_OUT_RESET = 1'h0;

endpackage

`default_nettype wire

// [core/lcdrd_row_cell.sv]
`timescale 1ns/100ps
`default_nettype none

// Selects the drive code of one row output from its stage, the enable and the polarity.
module lcdrd_row_cell
(
  input wire logic stage,
  input wire logic output_enable,
  input wire logic polarity,
  output logic [1:0] drive_code
);

  always_comb
  begin
    if (!output_enable)
    begin
      drive_code = lcdrd_pkg::DRIVE_GROUND;
    end
    else if (!stage)
    begin
      drive_code = lcdrd_pkg::DRIVE_GROUND;
    end
    else if (polarity)
    begin
      drive_code = lcdrd_pkg::DRIVE_POSITIVE;
    end
    else
    begin
      drive_code = lcdrd_pkg::DRIVE_NEGATIVE;
    end
  end

endmodule // lcdrd_row_cell

`default_nettype wire

// [core/lcdrd_row_driver.sv]
`timescale 1ns/100ps
`default_nettype none

module lcdrd_row_driver
#(
  parameter int unsigned ROWS = lcdrd_pkg::ROWS_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic register_clear_n,
  input wire logic output_enable,
  input wire logic polarity,
  output logic [ROWS-1:0] row_output_pos,
  output logic [ROWS-1:0] row_output_neg,
  output logic serial_out
);

  logic shift_clk_r;
  logic shift_fall;
  logic clear_req;
  logic [ROWS-1:0] stage_r;
  logic serial_out_r;
  wire [ROWS-1:0] stage_nxt;
  wire [ROWS-1:0] row_pos_all;
  wire [ROWS-1:0] row_neg_all;

  // A single stage would make the serial entry and the chain tap the same flip-flop.
  if (ROWS < 2)
  begin : g_rows_check
    $error("lcdrd_row_driver needs at least two stages");
  end

  // Each row keeps a positive and a negative enable inside its two-bit drive code.
  if ((lcdrd_pkg::DRIVE_POS_BIT > 1) || (lcdrd_pkg::DRIVE_NEG_BIT > 1))
  begin : g_code_width_check
    $error("lcdrd_row_driver drive code bits must lie within two bits");
  end

  if (lcdrd_pkg::DRIVE_POS_BIT == lcdrd_pkg::DRIVE_NEG_BIT)
  begin : g_code_split_check
    $error("lcdrd_row_driver drive code bits must differ");
  end

  // The shift clock is sampled on ref_clk; a high-then-low pair marks its falling edge.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      shift_clk_r <= lcdrd_pkg::SHIFT_CLK_RESET;
    end
    else
    begin
      shift_clk_r <= shift_clk;
    end
  end

  // A fall needs a high sample and then a low level, so a shift clock that is already low
  // when reset ends is not taken for a fall. A pulse that is not seen high on one ref_clk
  // edge and low on the next is missed.
  assign shift_fall = shift_clk_r && !shift_clk;

  // Clear is taken as a level at each edge and wins over any shift in the same cycle.
  assign clear_req = !register_clear_n;

  for (genvar s = 0; s < ROWS; s++)
  begin : g_stage
    logic shift_src;
    logic next_bit;
    logic [1:0] cell_code;
    logic pos_r;
    logic neg_r;

    if (s == 0)
    begin : g_head
      assign shift_src = serial_in;
    end
    else
    begin : g_link
      assign shift_src = stage_r[s-1];
    end

    always_comb
    begin
      if (clear_req)
      begin
        next_bit = lcdrd_pkg::STAGE_CLEAR;
      end
      else if (shift_fall)
      begin
        next_bit = shift_src;
      end
      else
      begin
        next_bit = stage_r[s];
      end
    end

    assign stage_nxt[s] = next_bit;

    // The cell sees the next stage value, so a row moves on the same edge as its stage.
    lcdrd_row_cell lcdrd_row_cell_inst
    (
      .stage(next_bit),
      .output_enable(output_enable),
      .polarity(polarity),
      .drive_code(cell_code)
    );

    // Both enables low means ground; the cell never raises both at once.
    always_ff @(posedge ref_clk)
    begin
      if (srst)
      begin
        pos_r <= lcdrd_pkg::ROW_OUT_RESET;
      end
      else
      begin
        pos_r <= cell_code[lcdrd_pkg::DRIVE_POS_BIT];
      end
    end

    always_ff @(posedge ref_clk)
    begin
      if (srst)
      begin
        neg_r <= lcdrd_pkg::ROW_OUT_RESET;
      end
      else
      begin
        neg_r <= cell_code[lcdrd_pkg::DRIVE_NEG_BIT];
      end
    end

    assign row_pos_all[s] = pos_r;
    assign row_neg_all[s] = neg_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stage_r <= {ROWS{lcdrd_pkg::STAGE_RESET}};
    end
    else
    begin
      stage_r <= stage_nxt;
    end
  end

  // The chain output is its own flip-flop fed like the last stage, so it always equals it.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      serial_out_r <= lcdrd_pkg::SERIAL_OUT_RESET;
    end
    else
    begin
      serial_out_r <= stage_nxt[ROWS-1];
    end
  end

  assign serial_out = serial_out_r;
  assign row_output_pos = row_pos_all;
  assign row_output_neg = row_neg_all;

endmodule // lcdrd_row_driver

`default_nettype wire

// [testbench/lcdrd_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module lcdrd_sva
#(parameter int unsigned ROWS = lcdrd_pkg::ROWS_DEFAULT)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic register_clear_n,
  input wire logic output_enable,
  input wire logic polarity,
  input wire logic [ROWS-1:0] row_output_pos,
  input wire logic [ROWS-1:0] row_output_neg,
  input wire logic serial_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [ROWS-1:0] p = row_output_pos;
  wire [ROWS-1:0] n = row_output_neg;
  wire on = output_enable && polarity;
  wire sh = register_clear_n && on;
  chk_never_both: assert property (!(|(p & n))) else $error("both");
  chk_off_ground: assert property (!output_enable |=> !(|(p | n))) else $error("off");
  chk_clear_zero: assert property (!register_clear_n |=> !(|(p | n)) && !serial_out)
    else $error("clr");
  chk_pos_only: assert property (on |=> !(|n)) else $error("neg");
  chk_neg_side: assert property (output_enable && !polarity |=> !(|p)) else $error("pos");
  chk_out_hold: assert property (register_clear_n && !$fell(shift_clk) |=> $stable(serial_out))
    else $error("hold");
  chk_load_in: assert property ($fell(shift_clk) && sh |=> p[0] == $past(serial_in))
    else $error("load");
  chk_shift_on: assert property (on ##1 $fell(shift_clk) && sh |=> p[ROWS-1:1] == $past(p[ROWS-2:0]))
    else $error("shift");
  chk_tail_out: assert property (output_enable |=> (p[ROWS-1] | n[ROWS-1]) == serial_out)
    else $error("tail");
endmodule // lcdrd_sva
bind lcdrd_row_driver lcdrd_sva #(.ROWS(ROWS)) lcdrd_sva_inst
(
  .ref_clk(ref_clk),
  .srst(srst),
  .shift_clk(shift_clk),
  .serial_in(serial_in),
  .register_clear_n(register_clear_n),
  .output_enable(output_enable),
  .polarity(polarity),
  .row_output_pos(row_output_pos),
  .row_output_neg(row_output_neg),
  .serial_out(serial_out)
);
`default_nettype wire

// [testbench/lcdrd_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module lcdrd_ctrl_model
(
  input wire logic ref_clk,
  output logic shift_clk = 1'h0,
  output logic serial_in = 1'h0
);
  // Shifts a word out first bit last-stage; the data line is inverted once its hold is over.
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge ref_clk) {shift_clk, serial_in} = {1'h1, w[i]};
      @(negedge ref_clk) shift_clk = 1'h0;
    end
    @(negedge ref_clk) serial_in = ~serial_in;
  endtask
endmodule // lcdrd_ctrl_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'h0, srst = 1'h1, register_clear_n = 1'h1, output_enable = 1'h1, polarity = 1'h1;
  logic shift_clk, serial_in, serial_out;
  logic [31:0] row_output_pos, row_output_neg;
  int err_count = 0, checks_done = 0;
  always #20 ref_clk = ~ref_clk;
  lcdrd_ctrl_model lcdrd_ctrl_model_inst
  (
    .ref_clk(ref_clk),
    .shift_clk(shift_clk),
    .serial_in(serial_in)
  );
  lcdrd_row_driver lcdrd_row_driver_inst
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .shift_clk(shift_clk),
    .serial_in(serial_in),
    .register_clear_n(register_clear_n),
    .output_enable(output_enable),
    .polarity(polarity),
    .row_output_pos(row_output_pos),
    .row_output_neg(row_output_neg),
    .serial_out(serial_out)
  );
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic shift_word();
    lcdrd_ctrl_model_inst.send(32'hA5C3_0F81);
    cmp(32'hA5C3_0F81, row_output_pos);
    cmp(32'h0000_0000, row_output_neg);
    cmp(32'h0000_0001, {31'h0000_0000, serial_out});
  endtask
  task automatic polarity_swing();
    for (int k = 0; k < 4; k++)
    begin
      polarity = ~polarity;
      repeat (4) @(negedge ref_clk);
      cmp(polarity ? 32'hA5C3_0F81 : 32'h0000_0000, row_output_pos);
      cmp(polarity ? 32'h0000_0000 : 32'hA5C3_0F81, row_output_neg);
    end
  endtask
  task automatic enable_off();
    output_enable = 1'h0;
    repeat (2) @(negedge ref_clk);
    cmp(32'h0000_0000, row_output_pos | row_output_neg);
    cmp(32'h0000_0001, {31'h0000_0000, serial_out});
    output_enable = 1'h1;
    repeat (2) @(negedge ref_clk);
    cmp(32'hA5C3_0F81, row_output_pos);
  endtask
  task automatic clear_hold();
    register_clear_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    cmp(32'h0000_0000, row_output_pos | row_output_neg);
    cmp(32'h0000_0000, {31'h0000_0000, serial_out});
    lcdrd_ctrl_model_inst.send(32'hFFFF_FFFF);
    cmp(32'h0000_0000, row_output_pos | row_output_neg);
    register_clear_n = 1'h1;
    lcdrd_ctrl_model_inst.send(32'h8000_0001);
    cmp(32'h8000_0001, row_output_pos);
    cmp(32'h0000_0001, {31'h0000_0000, serial_out});
  endtask
  initial
  begin
    repeat (2) @(negedge ref_clk);
    srst = 1'h0;
    shift_word();
    polarity_swing();
    enable_off();
    clear_hold();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
